// [core/ditf_top.sv]
// input terminal functions: comp mode select, analog hold, pulse counter
//
// Added by the designer: the APB register port and the register addresses.
`timescale 1ns/10ps
`include "ditf_defs.svh"

module ditf_top #(
    parameter logic [16:0] TICK_CYC = 17'(`DITF_TICK_CYC)
) (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // terminal pins
    input  wire logic [7:0]  input_terminal,
    input  wire logic        reset_terminal,
    // analog and up/down command, same clock
    input  wire logic [15:0] analog_cmd,
    input  wire logic        updown_up,
    input  wire logic        updown_down,
    // to speed loop
    output logic      [15:0] freq_cmd,
    output logic             prop_only_mode,
    output logic             integral_enable,
    output logic      [13:0] loop_gain,
    output logic      [31:0] pulse_count_monitor
);

    ditf_pkg::ditf_regs_type r_r;
    ditf_pkg::ditf_regs_type r_nxt;

    logic        setup;
    logic        wr_acc;
    logic        bad_addr;
    logic        bad_gain;
    logic [3:0]  hit_comp;
    logic [3:0]  hit_hold;
    logic [3:0]  hit_pulse_count_input;
    logic [3:0]  hit_pcc;
    logic        comp_mode_select_input;
    logic        analog_hold_input;
    logic        pulse_count_input;
    logic        pulse_count_clear_input;
    logic        meth_ok;
    logic        tick;
    logic [7:0]  meth;
    logic        mem_we;
    logic        mem_waddr;
    logic [15:0] mem_wdata;
    logic        mem_raddr;
    logic [15:0] mem_rdata;
    logic [16:0] sum;

    // lowest numbered terminal wins if a code is given twice
    function automatic logic [3:0] find_code(input logic [63:0] codes,
                                             input logic [7:0]  code);
        logic [3:0] res;
        res = 4'h0;
        for (int i = 7; i >= 0; i--) begin
            if (codes[i*8 +: 8] == code) begin
                res = {1'b1, 3'(i)};
            end
        end
        return res;
    endfunction : find_code

    function automatic logic gain_ok(input logic [31:0] v);
        return v <= 32'(`DITF_GAIN_MAX);
    endfunction : gain_ok

    assign hit_comp = find_code(r_r.codes, `DITF_CODE_COMP);
    assign hit_hold = find_code(r_r.codes, `DITF_CODE_HOLD);
    assign hit_pulse_count_input = find_code(r_r.codes, `DITF_CODE_PULSE_COUNT_INPUT);
    assign hit_pcc  = find_code(r_r.codes, `DITF_CODE_PCC);
    assign comp_mode_select_input  = hit_comp[3] & r_r.term[hit_comp[2:0]];
    assign analog_hold_input       = hit_hold[3] & r_r.term[hit_hold[2:0]];
    assign pulse_count_input       = hit_pulse_count_input[3] & r_r.term[hit_pulse_count_input[2:0]];
    assign pulse_count_clear_input = hit_pcc[3] & r_r.term[hit_pcc[2:0]];

    // method of the active motor set; third set offers no switchable code at motor 2, but takes SLV/ZSLV codes at motor 3
    always_comb begin
        case (r_r.ctrl[`DITF_F_MOTOR +: 2])
            2'h0:    meth = r_r.ctrl[`DITF_F_METH1 +: 8];
            2'h1:    meth = r_r.ctrl[`DITF_F_METH2 +: 8];
            default: meth = r_r.ctrl[`DITF_F_METH3 +: 8];
        endcase
        meth_ok = 1'b0;
        if (meth == `DITF_METH_SLV || meth == `DITF_METH_ZSLV) begin
            meth_ok = (r_r.ctrl[`DITF_F_MOTOR +: 2] != 2'h2);
        end else if (meth == `DITF_METH_SENSOR) begin
            meth_ok = (r_r.ctrl[`DITF_F_MOTOR +: 2] == 2'h0);
        end
    end

    assign setup    = psel && !penable;
    assign wr_acc   = psel && penable && pwrite;
    assign bad_gain = pwrite && !gain_ok(pwdata)
                    && (paddr == `DITF_A_PI_PROP || paddr == `DITF_A_PI_INT
                        || paddr == `DITF_A_PROP_ONLY);
    always_comb begin
        bad_addr = 1'b0;
        if (paddr[1:0] != 2'h0) begin
            bad_addr = 1'b1;
        end else if (paddr > `DITF_A_HELD) begin
            bad_addr = 1'b1;
        end else if (pwrite && paddr >= `DITF_A_STATUS) begin
            bad_addr = 1'b1;
        end
    end
    assign pready  = 1'b1;
    assign pslverr = psel && penable && (bad_addr || bad_gain);
    assign tick    = (r_r.tick_cnt == TICK_CYC - 17'h00001);
    assign sum     = 17'(r_r.held) + {r_r.offset[15], r_r.offset};

    always_comb begin
        r_nxt     = r_r;
        mem_we    = 1'b0;
        mem_waddr = 1'b0;
        mem_wdata = r_r.offset;
        mem_raddr = (r_r.st == ditf_pkg::DITF_TAKE_BASE) ? 1'b0 : 1'b1;

        // pins: the third stage must agree with the second before use
        r_nxt.s1 = {reset_terminal, input_terminal};
        r_nxt.s2 = r_r.s1;
        r_nxt.s3 = r_r.s2;
        for (int i = 0; i < 9; i++) begin
            if (r_r.s2[i] == r_r.s3[i]) begin
                r_nxt.term[i] = r_r.s3[i];
            end
        end

        // response filter: level must differ for resp+1 ticks of 2 ms;
        // any return to the old level restarts it, so fast trains cannot
        // alias through the tick sampling
        r_nxt.tick_cnt = tick ? 17'h00000 : r_r.tick_cnt + 17'h00001;
        if (pulse_count_input == r_r.pulse_flt) begin
            r_nxt.flt_cnt = 8'h00;
        end else if (tick) begin
            if (r_r.flt_cnt == r_r.resp) begin
                r_nxt.pulse_flt = pulse_count_input;
                r_nxt.flt_cnt   = 8'h00;
            end else begin
                r_nxt.flt_cnt = r_r.flt_cnt + 8'h01;
            end
        end
        r_nxt.pulse_prev = r_r.pulse_flt;
        if (pulse_count_clear_input) begin
            r_nxt.pcount = 32'h00000000;
        end else if (r_r.pulse_flt && !r_r.pulse_prev) begin
            r_nxt.pcount = r_r.pcount + 32'h00000001;
        end

        // apb: read data captured in setup, writes at the access edge
        if (setup) begin
            if (paddr == `DITF_A_ASSIGN_LO) begin
                r_nxt.prdata = r_r.codes[31:0];
            end else if (paddr == `DITF_A_ASSIGN_HI) begin
                r_nxt.prdata = r_r.codes[63:32];
            end else if (paddr == `DITF_A_CTRL) begin
                r_nxt.prdata = r_r.ctrl;
            end else if (paddr == `DITF_A_PI_PROP) begin
                r_nxt.prdata = {18'h00000, r_r.gain_pp};
            end else if (paddr == `DITF_A_PI_INT) begin
                r_nxt.prdata = {18'h00000, r_r.gain_pi};
            end else if (paddr == `DITF_A_PROP_ONLY) begin
                r_nxt.prdata = {18'h00000, r_r.gain_po};
            end else if (paddr == `DITF_A_RESP) begin
                r_nxt.prdata = {24'h000000, r_r.resp};
            end else if (paddr == `DITF_A_STEP) begin
                r_nxt.prdata = {16'h0000, r_r.step};
            end else if (paddr == `DITF_A_STATUS) begin
                r_nxt.prdata = {15'h0000, r_r.term, 5'h00,
                                analog_hold_input, meth_ok, prop_only_mode};
            end else if (paddr == `DITF_A_PCOUNT) begin
                r_nxt.prdata = r_r.pcount;
            end else if (paddr == `DITF_A_FREQ) begin
                r_nxt.prdata = {16'h0000, r_r.freq};
            end else if (paddr == `DITF_A_HELD) begin
                r_nxt.prdata = {r_r.offset, r_r.held};
            end else begin
                r_nxt.prdata = 32'h00000000;
            end
        end
        if (wr_acc && !bad_addr && !bad_gain) begin
            if (paddr == `DITF_A_ASSIGN_LO) begin
                r_nxt.codes[31:0] = pwdata;
            end else if (paddr == `DITF_A_ASSIGN_HI) begin
                r_nxt.codes[63:32] = pwdata;
            end else if (paddr == `DITF_A_CTRL) begin
                r_nxt.ctrl = {5'h00, pwdata[26:0]};
            end else if (paddr == `DITF_A_PI_PROP) begin
                r_nxt.gain_pp = pwdata[13:0];
            end else if (paddr == `DITF_A_PI_INT) begin
                r_nxt.gain_pi = pwdata[13:0];
            end else if (paddr == `DITF_A_PROP_ONLY) begin
                r_nxt.gain_po = pwdata[13:0];
            end else if (paddr == `DITF_A_RESP) begin
                r_nxt.resp = pwdata[7:0];
            end else if (paddr == `DITF_A_STEP) begin
                r_nxt.step = pwdata[15:0];
            end
        end

        // hold and up/down
        r_nxt.hold_prev = analog_hold_input;
        r_nxt.adj_pend  = 1'b0;
        case (r_r.st)
            ditf_pkg::DITF_SETTLE_ST: begin
                // wait for the pin synchronisers before looking at hold
                r_nxt.settle = r_r.settle + 3'h1;
                if (r_r.settle == `DITF_SETTLE) begin
                    r_nxt.st = ditf_pkg::DITF_TAKE_BASE;
                end
            end
            ditf_pkg::DITF_TAKE_BASE: begin
                r_nxt.st = ditf_pkg::DITF_TAKE_ADJ;
            end
            ditf_pkg::DITF_TAKE_ADJ: begin
                r_nxt.held = mem_rdata;
                r_nxt.st   = ditf_pkg::DITF_RUN;
            end
            ditf_pkg::DITF_RUN: begin
                r_nxt.st = ditf_pkg::DITF_RUN;
            end
            default: r_nxt.st = ditf_pkg::DITF_SETTLE_ST;
        endcase
        if (r_r.st == ditf_pkg::DITF_TAKE_ADJ) begin
            // offset is cleared in this state; the stored adjustment word is never read back
            r_nxt.offset = 16'h0000;
        end
        if (r_r.st == ditf_pkg::DITF_RUN) begin
            if (analog_hold_input && !r_r.hold_prev) begin
                r_nxt.held     = analog_cmd;
                r_nxt.offset   = 16'h0000;
                r_nxt.adj_pend = r_r.ctrl[`DITF_F_UDMEM];
                mem_we         = 1'b1;
                mem_wdata      = analog_cmd;
            end else if (analog_hold_input && (updown_up ^ updown_down))
            begin
                r_nxt.offset = updown_up ? r_r.offset + r_r.step
                                         : r_r.offset - r_r.step;
                r_nxt.adj_pend = r_r.ctrl[`DITF_F_UDMEM];
            end else if (r_r.adj_pend) begin
                mem_we    = 1'b1;
                mem_waddr = 1'b1;
            end
        end
        if (!analog_hold_input) begin
            r_nxt.freq = analog_cmd;
        end else if (sum[16]) begin
            r_nxt.freq = r_r.offset[15] ? 16'h0000 : 16'hFFFF;
        end else begin
            r_nxt.freq = sum[15:0];
        end

        // device reset through the terminal clears count, restarts restore
        if (r_r.term[8]) begin
            r_nxt.pcount = 32'h00000000;
            r_nxt.st     = ditf_pkg::DITF_SETTLE_ST;
            r_nxt.settle = 3'h0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            r_r        <= '0;
            r_r.gain_pp <= `DITF_GAIN_RST;
            r_r.gain_pi <= `DITF_GAIN_RST;
            r_r.gain_po <= `DITF_GAIN_RST;
            r_r.step   <= `DITF_STEP_RST;
            r_r.st     <= ditf_pkg::DITF_SETTLE_ST;
        end else begin
            r_r <= r_nxt;
        end
    end

    ditf_mem u_mem (
        .clk   (clk),
        .rst   (rst),
        .we    (mem_we),
        .waddr (mem_waddr),
        .wdata (mem_wdata),
        .raddr (mem_raddr),
        .rdata (mem_rdata)
    );

    // held value survives reset; off-hold restore uses the stored base
    assign prop_only_mode = meth_ok && comp_mode_select_input;
    assign integral_enable = !prop_only_mode;
    assign loop_gain = prop_only_mode ? r_r.gain_po : r_r.gain_pp;
    assign freq_cmd            = r_r.freq;
    assign prdata              = r_r.prdata;
    assign pulse_count_monitor = r_r.pcount;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_hold_rise;
        analog_hold_input && !r_r.hold_prev && r_r.st == ditf_pkg::DITF_RUN;
    endsequence
    sequence s_count_edge;
        r_r.pulse_flt && !r_r.pulse_prev && !pulse_count_clear_input
            && !r_r.term[8];
    endsequence

    a_mode_needs_code: assert property (prop_only_mode |-> hit_comp[3])
        else $error("prop-only mode without an assigned selector");
    a_mode_pi_off: assert property (!comp_mode_select_input |-> integral_enable)
        else $error("selector off but integral disabled");
    a_mode_none: assert property (!hit_comp[3] |-> !prop_only_mode)
        else $error("no selector yet prop-only mode");
    a_mode_third: assert property (r_r.ctrl[26:25] == 2'h2 |-> !prop_only_mode)
        else $error("third motor set switched mode");
    a_gain_select: assert property (prop_only_mode |-> loop_gain == r_r.gain_po)
        else $error("prop-only gain not selected");
    a_gain_range: assert property (r_r.gain_pp <= 14'h2710 && r_r.gain_pi <= 14'h2710)
        else $error("PI gain above 1000 percent");
    a_hold_latch: assert property (
        s_hold_rise ##1 analog_hold_input |=> freq_cmd == $past(r_r.held))
        else $error("held value not latched");
    a_hold_value: assert property (s_hold_rise |=> r_r.held == $past(analog_cmd))
        else $error("latched value differs from analog command");
    a_count_step: assert property (s_count_edge |=> pulse_count_monitor == $past(pulse_count_monitor) + 32'h1)
        else $error("count did not step by one");
    a_count_clear: assert property (pulse_count_clear_input |=> pulse_count_monitor == 32'h0)
        else $error("clear did not zero the count");
    a_count_rst: assert property (r_r.term[8] |=> pulse_count_monitor == 32'h0)
        else $error("reset terminal did not zero the count");

endmodule : ditf_top

// [core/ditf_defs.svh]
// offsets, field positions, reset values and timing counts
`ifndef DITF_DEFS_SVH
`define DITF_DEFS_SVH

`define DITF_A_ASSIGN_LO   8'h00
`define DITF_A_ASSIGN_HI   8'h04
`define DITF_A_CTRL        8'h08
`define DITF_A_PI_PROP     8'h0C
`define DITF_A_PI_INT      8'h10
`define DITF_A_PROP_ONLY   8'h14
`define DITF_A_RESP        8'h18
`define DITF_A_STEP        8'h1C
`define DITF_A_STATUS      8'h20
`define DITF_A_PCOUNT      8'h24
`define DITF_A_FREQ        8'h28
`define DITF_A_HELD        8'h2C

`define DITF_F_METH1       0
`define DITF_F_METH2       8
`define DITF_F_METH3       16
`define DITF_F_UDMEM       24
`define DITF_F_MOTOR       25

`define DITF_CODE_COMP     8'h2B
`define DITF_CODE_HOLD     8'h41
`define DITF_CODE_PULSE_COUNT_INPUT     8'h4A
`define DITF_CODE_PCC      8'h4B
`define DITF_METH_SLV      8'h03
`define DITF_METH_ZSLV     8'h04
`define DITF_METH_SENSOR   8'h05
`define DITF_GAIN_MAX      14'h2710
`define DITF_GAIN_RST      14'h03E8
`define DITF_STEP_RST      16'h0064

`define DITF_CLK_MHZ       40
`define DITF_TICK_US       2000
`define DITF_TICK_CYC      (`DITF_TICK_US * `DITF_CLK_MHZ)
`define DITF_SETTLE        3'h4

`endif

// [core/ditf_pkg.sv]
// types shared by the terminal function block
package ditf_pkg;

    typedef enum logic [1:0] {
        DITF_SETTLE_ST,
        DITF_TAKE_BASE,
        DITF_TAKE_ADJ,
        DITF_RUN
    } ditf_state_type;

    typedef struct packed {
        logic [8:0]     s1;
        logic [8:0]     s2;
        logic [8:0]     s3;
        logic [8:0]     term;
        logic [16:0]    tick_cnt;
        logic [7:0]     flt_cnt;
        logic           pulse_flt;
        logic           pulse_prev;
        logic [31:0]    pcount;
        logic [63:0]    codes;
        logic [31:0]    ctrl;
        logic [13:0]    gain_pp;
        logic [13:0]    gain_pi;
        logic [13:0]    gain_po;
        logic [7:0]     resp;
        logic [15:0]    step;
        ditf_state_type st;
        logic [2:0]     settle;
        logic           hold_prev;
        logic           adj_pend;
        logic [15:0]    held;
        logic [15:0]    offset;
        logic [15:0]    freq;
        logic [31:0]    prdata;
    } ditf_regs_type;

    typedef struct packed {
        logic [15:0]    w0;
        logic [15:0]    w1;
        logic [15:0]    rdata;
    } ditf_mem_type;

endpackage : ditf_pkg

// [core/ditf_mem.sv]
// two-word store for the held command and its up/down adjustment
`timescale 1ns/10ps
`include "ditf_defs.svh"

module ditf_mem (
    // clock
    input  wire logic        clk,
    input  wire logic        rst,
    // write port
    input  wire logic        we,
    input  wire logic        waddr,
    input  wire logic [15:0] wdata,
    // read port
    input  wire logic        raddr,
    output logic      [15:0] rdata
);

    ditf_pkg::ditf_mem_type m_r;
    ditf_pkg::ditf_mem_type m_nxt;

    always_comb begin
        m_nxt = m_r;
        if (we && !waddr) begin
            m_nxt.w0 = wdata;
        end
        if (we && waddr) begin
            m_nxt.w1 = wdata;
        end
        m_nxt.rdata = raddr ? m_r.w1 : m_r.w0;
    end

    // the words model nonvolatile cells: reset leaves them untouched
    always_ff @(posedge clk) begin
        m_r.w0 <= m_nxt.w0;
        m_r.w1 <= m_nxt.w1;
        if (rst) begin
            m_r.rdata <= 16'h0000;
        end else begin
            m_r.rdata <= m_nxt.rdata;
        end
    end

    assign rdata = m_r.rdata;

endmodule : ditf_mem

// [tb/ditf_pulse_source.sv]
// pulse train source standing in for an external counter input
`timescale 1ns/10ps

module ditf_pulse_source (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // request from the bench
    input  wire logic       go,
    input  wire logic [7:0] half,
    input  wire logic [7:0] count,
    // to the terminal pin
    output logic            pin,
    output logic            busy
);
    logic [7:0] cnt_r;
    logic [8:0] left_r;

    // equal high and low times keep the duty at one half
    always_ff @(posedge clk) begin
        if (rst) begin
            pin    <= 1'h0;
            busy   <= 1'h0;
            cnt_r  <= 8'h00;
            left_r <= 9'h000;
        end else if (!busy && go) begin
            busy   <= 1'h1;
            cnt_r  <= half;
            left_r <= {count, 1'h0};
        end else if (busy) begin
            if (cnt_r > 8'h01) begin
                cnt_r <= cnt_r - 8'h01;
            end else begin
                cnt_r  <= half;
                pin    <= ~pin;
                left_r <= left_r - 9'h001;
                busy   <= (left_r != 9'h001);
            end
        end
    end
endmodule : ditf_pulse_source

// [tb/ditf_top_bench.sv]
// self-checking bench for the input terminal functions
`timescale 1ns/10ps
`include "ditf_defs.svh"

module ditf_top_bench;
    logic        clk;
    logic        rst;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [7:0]  term_r;
    logic        pulse_pin;
    logic        reset_terminal;
    logic [15:0] analog_cmd;
    logic        updown_up;
    logic        updown_down;
    logic [15:0] freq_cmd;
    logic        prop_only_mode;
    logic        integral_enable;
    logic [13:0] loop_gain;
    logic [31:0] pulse_count_monitor;
    logic        go;
    logic [7:0]  half;
    logic [7:0]  count;
    logic        busy;
    logic [31:0] rd;
    logic        err;
    int          fails;
    int          total_checks;
    int          cyc;

    // short tick keeps the filter counts to a few cycles
    ditf_top #(.TICK_CYC(17'h00004)) ditf_top_inst (
        .clk(clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .input_terminal({term_r[7:3], pulse_pin, term_r[1:0]}),
        .reset_terminal(reset_terminal), .analog_cmd(analog_cmd),
        .updown_up(updown_up), .updown_down(updown_down),
        .freq_cmd(freq_cmd), .prop_only_mode(prop_only_mode),
        .integral_enable(integral_enable), .loop_gain(loop_gain),
        .pulse_count_monitor(pulse_count_monitor));

    ditf_pulse_source ditf_pulse_source_inst (
        .clk(clk), .rst(rst), .go(go), .half(half), .count(count),
        .pin(pulse_pin), .busy(busy));

    task automatic results;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : results

    task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk32

    task automatic chk1(input logic got, input logic exp);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: flag %b want %b", $time, got, exp);
        end
    endtask : chk1

    task automatic idle(input int n);
        repeat (n) @(posedge clk);
    endtask : idle

    // request held until pready is seen high at a rising edge
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        psel    <= 1'h1;
        penable <= 1'h0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'h1;
        @(posedge clk);
        while (pready !== 1'h1) begin
            @(posedge clk);
        end
        rd = prdata;
        err = pslverr;
        psel    <= 1'h0;
        penable <= 1'h0;
    endtask : apb

    task automatic pulses(input logic [7:0] h, input logic [7:0] n);
        half  <= h;
        count <= n;
        go    <= 1'h1;
        @(posedge clk);
        go <= 1'h0;
        @(posedge clk);
        while (busy === 1'h1) begin
            @(posedge clk);
        end
        idle(20);
    endtask : pulses

    task automatic test_regs;
        apb(1'h0, `DITF_A_PI_PROP, 32'h0); chk32(rd, 32'h3E8);
        apb(1'h1, `DITF_A_PI_PROP, 32'h2711); chk1(err, 1'h1);
        apb(1'h0, `DITF_A_PI_PROP, 32'h0); chk32(rd, 32'h3E8);
        apb(1'h1, `DITF_A_PI_PROP, 32'h2710); chk1(err, 1'h0);
        apb(1'h0, `DITF_A_PI_PROP, 32'h0); chk32(rd, 32'h2710);
        apb(1'h0, 8'h30, 32'h0); chk1(err, 1'h1);
        apb(1'h0, `DITF_A_PCOUNT, 32'h0); chk32(rd, 32'h0);
        $display("test regs done");
    endtask : test_regs

    task automatic test_comp;
        logic [31:0] ct [7] = '{32'h3, 32'h4, 32'h5, 32'h0,
                                32'h02000500, 32'h02000400, 32'h04030000};
        logic [6:0]  ex = 7'h27;
        term_r[0] <= 1'h1;
        idle(6);
        chk1(prop_only_mode, 1'h0);
        apb(1'h1, `DITF_A_PROP_ONLY, 32'h100);
        apb(1'h1, `DITF_A_PI_PROP, 32'h200);
        apb(1'h1, `DITF_A_CTRL, 32'h3);
        apb(1'h1, `DITF_A_ASSIGN_LO, 32'h2B);
        idle(2);
        chk1(prop_only_mode, 1'h1);
        chk1(integral_enable, 1'h0);
        chk32({18'h0, loop_gain}, 32'h100);
        term_r[0] <= 1'h0;
        idle(6);
        chk1(integral_enable, 1'h1);
        chk32({18'h0, loop_gain}, 32'h200);
        term_r[0] <= 1'h1;
        for (int i = 0; i < 7; i++) begin
            apb(1'h1, `DITF_A_CTRL, ct[i]);
            idle(2);
            chk1(prop_only_mode, ex[i]);
        end
        term_r[0] <= 1'h0;
        $display("test comp done");
    endtask : test_comp

    task automatic test_hold;
        apb(1'h1, `DITF_A_ASSIGN_LO, 32'h4B4A412B);
        apb(1'h1, `DITF_A_CTRL, 32'h01000003);
        analog_cmd <= 16'h1234;
        idle(3);
        chk32({16'h0, freq_cmd}, 32'h1234);
        term_r[1] <= 1'h1;
        idle(8);
        analog_cmd <= 16'h5555;
        idle(3);
        chk32({16'h0, freq_cmd}, 32'h1234);
        updown_up <= 1'h1;
        @(posedge clk);
        updown_up <= 1'h0;
        idle(3);
        chk32({16'h0, freq_cmd}, 32'h1298);
        updown_down <= 1'h1;
        @(posedge clk);
        updown_down <= 1'h0;
        idle(3);
        chk32({16'h0, freq_cmd}, 32'h1234);
        $display("test hold done");
    endtask : test_hold

    task automatic test_count;
        apb(1'h1, `DITF_A_RESP, 32'h1);
        // three-cycle levels never outlast two ticks
        pulses(8'h03, 8'h04);
        chk32(pulse_count_monitor, 32'h0);
        pulses(8'h28, 8'h05);
        chk32(pulse_count_monitor, 32'h5);
        apb(1'h0, `DITF_A_PCOUNT, 32'h0); chk32(rd, 32'h5);
        term_r[3] <= 1'h1;
        idle(8);
        chk32(pulse_count_monitor, 32'h0);
        pulses(8'h28, 8'h02);
        chk32(pulse_count_monitor, 32'h0);
        term_r[3] <= 1'h0;
        idle(8);
        pulses(8'h28, 8'h01);
        chk32(pulse_count_monitor, 32'h1);
        $display("test count done");
    endtask : test_count

    task automatic test_restore;
        reset_terminal <= 1'h1;
        idle(8);
        chk32(pulse_count_monitor, 32'h0);
        reset_terminal <= 1'h0;
        idle(8);
        pulses(8'h28, 8'h01);
        chk32(pulse_count_monitor, 32'h1);
        rst <= 1'h1;
        idle(2);
        rst <= 1'h0;
        idle(12);
        chk32(pulse_count_monitor, 32'h0);
        apb(1'h0, `DITF_A_HELD, 32'h0); chk32({16'h0, rd[15:0]}, 32'h1234);
        $display("test restore done");
    endtask : test_restore

    initial begin
        clk = 1'h0;
        forever #12.5 clk = ~clk;
    end

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fails++;
            results;
        end
    end

    initial begin
        {psel, penable, pwrite, go, updown_up, updown_down} = 6'h0;
        {paddr, pwdata, term_r, half, count} = 64'h0;
        {reset_terminal, analog_cmd} = 17'h0;
        {fails, total_checks, cyc} = 96'h0;
        rst = 1'h1;
        idle(4);
        rst <= 1'h0;
        test_regs;
        test_comp;
        test_hold;
        test_count;
        test_restore;
        results;
    end
endmodule : ditf_top_bench
